// *** shared/pixel_fifo_pkg.sv ***
// constants and types for the asynchronous pixel output port
package pixel_fifo_pkg;
    localparam int          FIFO_DEPTH   = 40;
    localparam int          AF_LEVEL     = 32;
    localparam int          AF_LEVEL_LOW = 20;
    localparam int          AE_LEVEL     = 8;
    localparam int          CLEAR_EDGES  = 4;
    localparam int          WORD_W       = 16;
    // register map, byte addresses
    localparam logic [3:0]  CTRL_OFFSET   = 4'h0;
    localparam logic [3:0]  STATUS_OFFSET = 4'h4;
    // control fields
    localparam int          CTRL_ENABLE_BIT = 0;
    localparam int          CTRL_BURST_BIT  = 1;
    localparam int          CTRL_LOWAF_BIT  = 2;
    localparam logic [2:0]  CTRL_RESET      = 3'h1;
    // status fields
    localparam int          STAT_COUNT_LSB  = 0;
    localparam int          STAT_AF_BIT     = 8;
    localparam int          STAT_AE_BIT     = 9;
    localparam int          STAT_DP_BIT     = 10;
    localparam int          STAT_DROP_BIT   = 11;
    // in-band code words
    localparam logic [15:0] CODE_EOL_ODD    = 16'h01ff;
    localparam logic [15:0] CODE_EOL_EVEN   = 16'h01fe;
    localparam logic [15:0] CODE_FS         = 16'h05ff;
    localparam logic [15:0] CODE_FS_DRAINED = 16'h06ff;

    typedef enum logic [1:0] {
        KIND_PIXEL = 2'b00,
        KIND_EOL   = 2'b01,
        KIND_FS    = 2'b10
    } entry_kind_t;
endpackage : pixel_fifo_pkg

// *** src/async_pixel_fifo_port.sv ***
// asynchronous pixel output port: 40-word fifo, flags and in-band codes
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - buffer pixels in 40-word fifo when selected
// - write only active valid pixels and codes
// - insert only line-end and field codes
// - codes only in blanking, never over pixels
// - burst mode feeds data-present to read enable
// - data-present rises with almost-full, falls empty
// - read only while read enable high
// - burst mode drives data from almost-full until empty
// - data-present one read cycle before data
// - burst load clock only while data present
// - active and burst load clock mark pixels only
// - outputs undefined after last word read
// - system mode load clock is delayed read clock
// - line end code 01FF/01FE, line sync low
// - field code 05FF/06FF after line end
// - enable low holds active indication low
// - almost-full above 31 stored, option lowers
// - each enabled read edge presents next word
// - clear low four read edges empties fifo
module async_pixel_fifo_port
    import pixel_fifo_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // decoded pixel stream
    input  wire logic        pix_strobe,
    input  wire logic        pix_active,
    input  wire logic        pix_valid,
    input  wire logic [15:0] pix_data,
    input  wire logic        pix_cb,
    input  wire logic        line_end,
    input  wire logic        field_end,
    input  wire logic        field_even,
    // read port
    input  wire logic        fifo_read_clock,
    input  wire logic        fifo_read_enable,
    input  wire logic        fifo_clear_n,
    output logic      [15:0] video_data_bus,
    output logic             pixel_active,
    output logic             line_sync_n,
    output logic             field_sync_n,
    output logic             blue_chroma_marker,
    output logic             fifo_data_present,
    output logic             almost_full_flag,
    output logic             almost_empty_flag,
    output logic             qualified_load_clock
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int EW = WORD_W + 3;

    if (DEPTH <= AF_LEVEL || AF_LEVEL_LOW >= AF_LEVEL || AE_LEVEL >= AF_LEVEL_LOW) begin : g_chk
        $error("fifo depth must exceed the almost-full levels");
    end

    logic [EW-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;
    logic [2:0]    ctrl_reg;
    logic          drop_reg;
    logic          eol_pend_reg;
    logic          fs_pend_reg;
    logic          hold_reg;
    logic          rclk_reg;
    logic [2:0]    clr_cnt_reg;

    logic          api_en;
    logic          burst;
    logic          qual;
    logic          wr_req;
    logic          wr_do;
    logic          drop;
    logic          full;
    logic          rd_rise;
    logic          read_en;
    logic          pop;
    logic          clear;
    logic [CW-1:0] af_thr;
    entry_kind_t   wr_kind;
    entry_kind_t   rd_kind;
    logic [EW-1:0] wr_word;
    logic [EW-1:0] rd_word;
    logic [15:0]   code_word;

    assign api_en  = ctrl_reg[CTRL_ENABLE_BIT];
    assign burst   = ctrl_reg[CTRL_BURST_BIT];
    assign af_thr  = ctrl_reg[CTRL_LOWAF_BIT] ? CW'(AF_LEVEL_LOW) : CW'(AF_LEVEL);
    assign full    = (count_reg == CW'(DEPTH));

    // write side
    assign qual    = api_en & pix_strobe & pix_active & pix_valid;
    // codes wait for a cycle with no qualifying pixel
    always_comb begin
        wr_kind   = KIND_PIXEL;
        code_word = field_even ? CODE_EOL_EVEN : CODE_EOL_ODD;
        if (!qual && eol_pend_reg) begin
            wr_kind = KIND_EOL;
        end else if (!qual && fs_pend_reg) begin
            wr_kind   = KIND_FS;
            code_word = (count_reg == '0) ? CODE_FS_DRAINED : CODE_FS;
        end
    end
    assign wr_word = (wr_kind == KIND_PIXEL) ? {wr_kind, pix_cb, pix_data}
                                             : {wr_kind, 1'b0, code_word};
    assign wr_req  = qual | eol_pend_reg | fs_pend_reg;
    assign wr_do   = wr_req & ~full & ~clear;
    assign drop    = qual & full;

    always_ff @(posedge clk_sys) begin
        if (wr_do) begin
            mem[wr_ptr_reg] <= wr_word;
        end
    end

    // pending codes: a new event beats the write that retires the old one
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            eol_pend_reg <= 1'b0;
            fs_pend_reg  <= 1'b0;
        end else if (clear || !api_en) begin
            eol_pend_reg <= 1'b0;
            fs_pend_reg  <= 1'b0;
        end else begin
            eol_pend_reg <= line_end | (eol_pend_reg & ~(wr_do & wr_kind == KIND_EOL));
            fs_pend_reg  <= field_end | (fs_pend_reg & ~(wr_do & wr_kind == KIND_FS));
        end
    end

    // read side; read clock is a sampled input
    assign rd_rise = fifo_read_clock & ~rclk_reg;
    assign read_en = burst ? fifo_data_present : fifo_read_enable;
    assign pop     = rd_rise & read_en & (count_reg != '0) & ~clear;
    assign rd_word = mem[rd_ptr_reg];
    assign rd_kind = entry_kind_t'(rd_word[EW-1 -: 2]);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rclk_reg    <= 1'b0;
            clr_cnt_reg <= 3'h0;
        end else begin
            rclk_reg <= fifo_read_clock;
            if (fifo_clear_n) begin
                clr_cnt_reg <= 3'h0;
            end else if (rd_rise && clr_cnt_reg != 3'(CLEAR_EDGES)) begin
                clr_cnt_reg <= clr_cnt_reg + 3'h1;
            end
        end
    end
    assign clear = (clr_cnt_reg == 3'(CLEAR_EDGES));

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else if (clear) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (wr_do) begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + CW'(wr_do) - CW'(pop);
        end
    end

    // outputs move only on read clock edges
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            video_data_bus     <= 16'h0000;
            pixel_active       <= 1'b0;
            line_sync_n        <= 1'b1;
            field_sync_n       <= 1'b1;
            blue_chroma_marker <= 1'b0;
        end else if (pop) begin
            video_data_bus     <= rd_word[WORD_W-1:0];
            pixel_active       <= (rd_kind == KIND_PIXEL);
            line_sync_n        <= (rd_kind != KIND_EOL);
            field_sync_n       <= (rd_kind != KIND_FS);
            blue_chroma_marker <= (rd_kind == KIND_PIXEL) & rd_word[WORD_W];
        end else if (rd_rise) begin
            // nothing read: data left as is, reader must ignore it
            pixel_active       <= 1'b0;
            blue_chroma_marker <= 1'b0;
        end
    end

    // flags
    assign almost_full_flag  = (count_reg >= af_thr);
    assign almost_empty_flag = (count_reg <= CW'(AE_LEVEL));
    // set with almost-full, released only when empty
    assign fifo_data_present = almost_full_flag | (hold_reg & (count_reg != '0));

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            hold_reg <= 1'b0;
        end else begin
            hold_reg <= fifo_data_present;
        end
    end

    // burst: pixel-gated copy of the read clock; system: plain copy
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            qualified_load_clock <= 1'b0;
        end else if (burst) begin
            qualified_load_clock <= rclk_reg & pixel_active;
        end else begin
            qualified_load_clock <= rclk_reg;
        end
    end

    // register port
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl_reg <= CTRL_RESET;
            drop_reg <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == CTRL_OFFSET) begin
                ctrl_reg <= reg_wdata[2:0];
            end
            // an overflow in the clearing cycle still shows
            drop_reg <= drop | (drop_reg & ~(reg_wr && reg_addr == STATUS_OFFSET
                                             && reg_wdata[STAT_DROP_BIT]));
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= 32'h0000_0000;
            if (reg_rd && reg_addr == CTRL_OFFSET) begin
                reg_rdata[2:0] <= ctrl_reg;
            end else if (reg_rd && reg_addr == STATUS_OFFSET) begin
                reg_rdata[STAT_COUNT_LSB +: CW] <= count_reg;
                reg_rdata[STAT_AF_BIT]          <= almost_full_flag;
                reg_rdata[STAT_AE_BIT]          <= almost_empty_flag;
                reg_rdata[STAT_DP_BIT]          <= fifo_data_present;
                reg_rdata[STAT_DROP_BIT]        <= drop_reg;
            end
        end
    end

    // checks
    default clocking cb_main @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_count_bound: assert property (count_reg <= CW'(DEPTH))
        else $error("fifo count above depth");
    a_full_keeps: assert property (drop |=> $stable(wr_ptr_reg) || $past(clear))
        else $error("full fifo accepted a pixel");
    a_code_slot: assert property (wr_do && wr_kind != KIND_PIXEL |-> !qual)
        else $error("code written over a pixel");
    a_drop_unqual: assert property (wr_do && wr_kind == KIND_PIXEL |-> qual)
        else $error("unqualified pixel written");
    a_present_fall: assert property ($fell(fifo_data_present) |-> count_reg == '0)
        else $error("data present fell with data stored");
    a_present_rise: assert property ($rose(fifo_data_present) |-> almost_full_flag)
        else $error("data present rose without almost full");
    a_burst_feed: assert property (burst && rd_rise && fifo_data_present && count_reg != '0
                                   && !clear |-> pop)
        else $error("burst mode missed a read");
    a_no_enable: assert property (rd_rise && !read_en |=> !pixel_active)
        else $error("active high without read enable");
    a_eol_word: assert property (pop && rd_kind == KIND_EOL |=> !line_sync_n && !pixel_active
                                 && video_data_bus[15:8] == 8'h01)
        else $error("line end code malformed");
    a_fs_word: assert property (pop && rd_kind == KIND_FS |=> !field_sync_n && !pixel_active
                                && video_data_bus[7:0] == 8'hff)
        else $error("field code malformed");
    a_clear_empty: assert property (!fifo_clear_n && rd_rise && clr_cnt_reg == 3'(CLEAR_EDGES - 1)
                                    |-> ##2 count_reg == '0)
        else $error("clear did not empty fifo");
    a_qualified_load_clock_copy: assert property (!burst && !$past(burst) |-> qualified_load_clock
                                  == $past(fifo_read_clock, 2))
        else $error("load clock not a copy of read clock");

    c_pixel_read: cover property (pop && rd_kind == KIND_PIXEL ##1 pixel_active);
    c_line_code: cover property (pop && rd_kind == KIND_EOL);
    c_field_code: cover property (pop && rd_kind == KIND_FS);
    c_full_drop: cover property (drop);
    c_clear: cover property (clear && count_reg != '0);
endmodule : async_pixel_fifo_port

`default_nettype wire

// *** test/reader_model.sv ***
// capture-side model: makes the read clock and read enable
`timescale 1ns/100ps
`default_nettype none
module reader_model (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // bench control: 0 off, 1 held on, 2 driven from flags
    input  wire logic       run,
    input  wire logic [1:0] en_mode,
    // flags from the port
    input  wire logic       almost_full_flag,
    input  wire logic       almost_empty_flag,
    // read side
    output logic            fifo_read_clock,
    output logic            fifo_read_enable
);
    logic auto_en_reg;

    // clock stands still between bursts; half the system rate at most
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) fifo_read_clock <= 1'b0;
        else fifo_read_clock <= run ? ~fifo_read_clock : 1'b0;
    end

    // stops early so a line is never drained empty
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) auto_en_reg <= 1'b0;
        else if (almost_full_flag) auto_en_reg <= 1'b1;
        else if (almost_empty_flag) auto_en_reg <= 1'b0;
    end

    assign fifo_read_enable = en_mode == 2'd1 || (en_mode == 2'd2 && auto_en_reg);
endmodule : reader_model
`default_nettype wire

// *** test/async_pixel_fifo_port_test.sv ***
// self-checking bench for the asynchronous pixel output port
`timescale 1ns/100ps
`default_nettype none
module async_pixel_fifo_port_test;
    import pixel_fifo_pkg::*;
    logic        clk_sys = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        pix_strobe = 1'b0, pix_active = 1'b0, pix_valid = 1'b0, pix_cb = 1'b0;
    logic        line_end = 1'b0, field_end = 1'b0, field_even = 1'b0, fifo_clear_n = 1'b1;
    logic        run = 1'b0, burst = 1'b0, lowaf = 1'b0, drop = 1'b0;
    logic [1:0]  en_mode = 2'd0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] pix_data = 16'h0000, video_data_bus;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
    logic        fifo_read_clock, fifo_read_enable, pixel_active, line_sync_n, field_sync_n;
    logic        blue_chroma_marker, fifo_data_present, almost_full_flag, almost_empty_flag;
    logic        qualified_load_clock, rck_prev = 1'b0, s1 = 1'b0, s2 = 1'b0;
    logic        pend = 1'b0, rose = 1'b0, pa1 = 1'b0;
    logic [18:0] q[$], e;
    int          bad_count = 0, checks_done = 0, cyc = 0;

    always #20 clk_sys = ~clk_sys;

    async_pixel_fifo_port async_pixel_fifo_port_inst (.clk_sys, .reset, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .pix_strobe, .pix_active, .pix_valid, .pix_data, .pix_cb,
        .line_end, .field_end, .field_even, .fifo_read_clock, .fifo_read_enable, .fifo_clear_n,
        .video_data_bus, .pixel_active, .line_sync_n, .field_sync_n, .blue_chroma_marker,
        .fifo_data_present, .almost_full_flag, .almost_empty_flag, .qualified_load_clock);

    reader_model reader_model_inst (.clk_sys, .reset, .run, .en_mode, .almost_full_flag,
        .almost_empty_flag, .fifo_read_clock, .fifo_read_enable);

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done

    function automatic logic [31:0] stat(input int n);
        stat = 32'(n) | {22'h0, n <= AE_LEVEL, n >= (lowaf ? AF_LEVEL_LOW : AF_LEVEL), 8'h00};
        stat = stat | {20'h0, drop, 11'h0};
    endfunction : stat

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rdreg(input logic [3:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        rd = reg_rdata;
    endtask : rdreg

    task automatic put(input logic a, input logic v);
        logic [15:0] d;
        logic        c;
        d = 16'($urandom);
        c = 1'($urandom);
        @(posedge clk_sys);
        pix_strobe <= 1'b1;
        pix_active <= a;
        pix_valid <= v;
        pix_data <= d;
        pix_cb <= c;
        @(posedge clk_sys);
        pix_strobe <= 1'b0;
        @(negedge clk_sys);
        if (a && v && q.size() < FIFO_DEPTH) q.push_back({c, KIND_PIXEL, d});
        else if (a && v) drop = 1'b1;
    endtask : put

    // codes land one cycle after the pulse, line code first
    task automatic code(input logic le, input logic fe, input logic ev);
        @(posedge clk_sys);
        line_end <= le;
        field_end <= fe;
        field_even <= ev;
        @(posedge clk_sys);
        line_end <= 1'b0;
        field_end <= 1'b0;
        if (le) begin
            @(posedge clk_sys);
            @(negedge clk_sys);
            q.push_back({1'b0, KIND_EOL, ev ? CODE_EOL_EVEN : CODE_EOL_ODD});
        end
        if (fe) begin
            @(posedge clk_sys);
            @(negedge clk_sys);
            q.push_back({1'b0, KIND_FS, q.size() == 0 ? CODE_FS_DRAINED : CODE_FS});
        end
    endtask : code

    task automatic wait_empty();
        repeat (3000) if (q.size() > 0) @(posedge clk_sys);
        repeat (4) @(posedge clk_sys);
        rdreg(STATUS_OFFSET);
        check("status", rd & 32'hfffffbff, stat(q.size()));
    endtask : wait_empty

    // a read is due where the sampled read clock rose with enable and data
    always @(posedge clk_sys) begin
        cyc++;
        rose = fifo_read_clock && !rck_prev;
        pend = rose && (burst ? fifo_data_present : fifo_read_enable) && q.size() > 0;
        s2 = s1;
        s1 = fifo_read_clock;
        pa1 = pixel_active;
        rck_prev = fifo_read_clock;
        if (cyc > 60000) begin
            bad_count++;
            test_done();
        end
    end

    always @(negedge clk_sys) begin
        if (pend) begin
            e = q.pop_front();
            check("data", video_data_bus, e[15:0]);
            check("active", pixel_active, e[17:16] == KIND_PIXEL);
            check("line sync", line_sync_n, e[17:16] != KIND_EOL);
            check("field sync", field_sync_n, e[17:16] != KIND_FS);
            check("cb", blue_chroma_marker, e[18] && e[17:16] == KIND_PIXEL);
        end else if (rose) check("idle active", pixel_active, 1'b0);
        // burst gates the delayed read clock with the pixel indication
        if (!reset) check("load clock", qualified_load_clock,
                          burst ? s2 & pa1 : s2);
    end

    initial begin
        void'($urandom(32'hb5d2));
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        rdreg(CTRL_OFFSET);
        check("ctrl", rd, 32'(CTRL_RESET));
        rdreg(STATUS_OFFSET);
        check("status", rd & 32'hfffffbff, stat(0));
        wr(4'h8, 32'hffffffff);
        rdreg(4'h8);
        check("unmapped", rd, 32'h0);
        rdreg(CTRL_OFFSET);
        check("ctrl", rd, 32'(CTRL_RESET));
        $display("test registers done");
        for (int i = 0; i < 63; i++) begin
            put(i > 59 || $urandom_range(7) != 0, i > 59 || $urandom_range(7) != 0);
            check("af", almost_full_flag, q.size() >= AF_LEVEL);
            check("dp", fifo_data_present, q.size() >= AF_LEVEL);
            check("ae", almost_empty_flag, q.size() <= AE_LEVEL);
        end
        rdreg(STATUS_OFFSET);
        check("full", rd & 32'hfffffbff, stat(q.size()));
        wr(STATUS_OFFSET, 32'h800);
        drop = 1'b0;
        rdreg(STATUS_OFFSET);
        check("drop clear", rd & 32'hfffffbff, stat(q.size()));
        en_mode <= 2'd1;
        run <= 1'b1;
        wait_empty();
        check("dp empty", fifo_data_present, 1'b0);
        $display("test fill and drain done");
        en_mode <= 2'd0;
        run <= 1'b0;
        code(1'b0, 1'b1, 1'b0);
        repeat (3) put(1'b1, 1'b1);
        code(1'b1, 1'b0, 1'b1);
        repeat (3) put(1'b1, 1'b0);
        repeat (3) put(1'b1, 1'b1);
        code(1'b1, 1'b1, 1'b0);
        put(1'b1, 1'b1);
        en_mode <= 2'd1;
        run <= 1'b1;
        wait_empty();
        $display("test codes done");
        en_mode <= 2'd2;
        repeat (36) put(1'b1, 1'b1);
        repeat (300) @(posedge clk_sys);
        rdreg(STATUS_OFFSET);
        check("flag mode", rd & 32'hfffffbff, stat(q.size()));
        $display("test flag mode done");
        en_mode <= 2'd0;
        run <= 1'b0;
        lowaf = 1'b1;
        wr(CTRL_OFFSET, 32'h5);
        repeat (22) begin
            put(1'b1, 1'b1);
            check("af low", almost_full_flag, q.size() >= AF_LEVEL_LOW);
        end
        @(posedge clk_sys);
        fifo_clear_n <= 1'b0;
        run <= 1'b1;
        repeat (10) @(posedge clk_sys);
        q.delete();
        fifo_clear_n <= 1'b1;
        run <= 1'b0;
        rdreg(STATUS_OFFSET);
        check("clear", rd & 32'hfffffbff, stat(0));
        $display("test clear done");
        lowaf = 1'b0;
        burst = 1'b1;
        wr(CTRL_OFFSET, 32'h3);
        run <= 1'b1;
        repeat (31) put(1'b1, 1'b1);
        check("burst wait", fifo_data_present, 1'b0);
        put(1'b1, 1'b1);
        check("burst go", fifo_data_present, 1'b1);
        wait_empty();
        check("burst end", fifo_data_present, 1'b0);
        $display("test burst done");
        test_done();
    end
endmodule : async_pixel_fifo_port_test
`default_nettype wire
